// *** pkg/asp_pkg.sv ***
// Purpose: shared constants and state types of the async serial channel
// Assumes: APB slave, 32-bit data, 8-bit byte addresses
// Notes:   every offset and the reset values of intf, mode, baud and carrier live here
package asp_pkg;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_MODE  = 8'h00;
    localparam logic [7:0] OFS_CTRL  = 8'h04;
    localparam logic [7:0] OFS_CLK   = 8'h08;
    localparam logic [7:0] OFS_BAUD  = 8'h0c;
    localparam logic [7:0] OFS_CARR  = 8'h10;
    localparam logic [7:0] OFS_TXD   = 8'h14;
    localparam logic [7:0] OFS_RXD   = 8'h18;
    localparam logic [7:0] OFS_INTF  = 8'h1c;
    localparam logic [7:0] OFS_INTE  = 8'h20;
    // mode field positions
    localparam int M_DLEN = 0;
    localparam int M_STOP = 1;
    localparam int M_PEN  = 2;
    localparam int M_PODD = 3;
    localparam int M_DIV4 = 4;
    localparam int M_RINV = 5;
    localparam int M_TINV = 6;
    localparam int M_PUP  = 7;
    localparam int M_OD   = 8;
    localparam int M_IR   = 9;
    localparam int M_CEN  = 10;
    localparam int M_CSEL = 11;
    // clock register field positions
    localparam int C_SRC = 0;
    localparam int C_DIV = 4;
    localparam int C_DBR = 8;
    // flag positions
    localparam int F_RX1 = 0;
    localparam int F_RX2 = 1;
    localparam int F_TBE = 2;
    localparam int F_TEND = 3;
    localparam int F_PE  = 4;
    localparam int F_FE  = 5;
    localparam int F_OE  = 6;
    localparam int F_TX_BUSY_FLAG = 8;
    localparam int F_RX_BUSY_FLAG = 9;
    // reset values
    localparam logic [6:0]  INTF_RST = 7'h04;
    localparam logic [11:0] MODE_RST = 12'h000;
    localparam logic [7:0]  BRT_RST  = 8'h00;
    localparam logic [3:0]  FMD_RST  = 4'h0;
    localparam logic [7:0]  CRP_RST  = 8'h00;
    // oversampling factors and infrared pulse fraction
    localparam logic [4:0]  OVS16 = 5'h10;
    localparam logic [4:0]  OVS4  = 5'h04;
    localparam logic [1:0]  IR_NUM = 2'h3;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
        TX_PAR = 5'b01000, TX_STOP = 5'b10000
    } asp_tx_state_type;
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
        RX_PAR = 5'b01000, RX_STOP = 5'b10000
    } asp_rx_state_type;

    typedef struct packed {
        logic [12:0] cnt;
    } asp_baud_state_type;

    typedef struct packed {
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic [11:0]      mode;
        logic             enable;
        logic [8:0]       clk_cfg;
        logic [7:0]       baud_integer;
        logic [3:0]       frac;
        logic [7:0]       crper;
        logic [6:0]       inte;
        logic [6:0]       intf;
        logic [7:0]       txbuf;
        logic             txbuf_full;
        asp_tx_state_type tx_st;
        logic [7:0]       tx_sh;
        logic [2:0]       tx_idx;
        logic             tx_stop2;
        asp_rx_state_type rx_st;
        logic [7:0]       rx_sh;
        logic [2:0]       rx_idx;
        logic             rx_stop2;
        logic             rx_perr;
        logic             rx_ferr;
        logic             ir_hold;
        logic [1:0][7:0]  fifo_d;
        logic [1:0]       fifo_pe;
        logic [1:0]       fifo_fe;
        logic [1:0]       fifo_cnt;
        logic [2:0]       div_cnt;
        logic [7:0]       car_cnt;
        logic             car_wave;
        logic             in_s1;
        logic             in_s2;
        logic             dbg_s1;
        logic             dbg_s2;
        logic             serial_out;
        logic             out_oe;
        logic             irq;
    } asp_state_type;
endpackage : asp_pkg

// *** logic/asp_baud.sv ***
// Purpose: bit timer for one direction of the channel
// Assumes: tick is one operating-clock cycle, run low parks the counter
// Notes:   fractional cycles are added once per bit
`timescale 1ns/1ps
`default_nettype none
module asp_baud (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic [7:0] baud_integer,
    input  wire logic [3:0] frac,
    input  wire logic       div4,
    output logic            bit_mid,
    output logic            bit_end,
    output logic            ir_win
);
    asp_pkg::asp_baud_state_type s, s_next;
    logic [12:0] total;
    logic [16:0] cnt16;
    logic [16:0] tot3;

    // bit length and strobes
    always_comb
    begin
        total = (13'(baud_integer) + 13'h1)
                * 13'(div4 ? asp_pkg::OVS4 : asp_pkg::OVS16) + 13'(frac);
        bit_end = run & tick & (s.cnt == total - 13'h1);
        bit_mid = run & tick & (s.cnt == (total >> 1));
        cnt16 = {s.cnt, 4'h0};
        tot3 = 17'(total) * 17'(asp_pkg::IR_NUM);
        ir_win = cnt16 < tot3;
        s_next = s;
        if (!run)
            s_next.cnt = 13'h0;
        else if (bit_end)
            s_next.cnt = 13'h0;
        else if (tick)
            s_next.cnt = s.cnt + 13'h1;
    end

    // counter register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= s_next;
    end
endmodule : asp_baud
`default_nettype wire

// *** logic/asp_channel.sv ***
// Purpose: async serial channel with infrared and carrier output, APB regs
// Assumes: MCLK 25 MHz, clock-source ticks are MCLK-domain pulses
// Notes:   registers at byte offsets held in asp_pkg
// What this block does
// - frame is one start bit, data LSB first, optional parity, stop bits.
// - start bit always one bit long, transmit and receive.
// - data length select 0 gives seven bits, 1 gives eight.
// - stop length select 0 gives one stop bit, 1 gives two.
// - parity enable adds parity; odd select 1 odd, 0 even.
// - two-entry receive buffer, one-entry transmit buffer, full duplex.
// - parity, framing and overrun errors each have a status flag.
// - seven separate interrupt causes for buffers, end and errors.
// - bit period is (integer+1) times ratio plus fraction clock cycles.
// - baud integer is eight bits, fraction four bits.
// - separate inversion of serial input and serial output.
// - pad outputs for input pull-up and open-drain output mode.
// - serial output idles high when not inverted, unless the carrier is gated onto high periods.
// - debug without debug run freezes channel; with it keeps running.
// - operating clock from 2-bit source select and 2-bit divider.
// - return-to-zero infrared modulator and demodulator in infrared mode.
// - carrier gated onto high or low data periods by select bit.
// - infrared low pulse is 3/16 bit; use ratio 1/16 then.
// - buffered byte moves to shifter; sets empty, busy; end sets done.
// - low starts reception, busy set; stop pushes byte, sets flags.
// - stop bit of zero still stores byte, framing flag when readable.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asp_channel (
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [3:0]  CLK_SRC_TICK,
    input  wire logic        DEBUG_MODE,
    input  wire logic        SERIAL_IN_PIN,
    output logic             SERIAL_OUT_PIN,
    output logic             SERIAL_OUT_OE,
    output logic             INPUT_PULLUP_EN,
    output logic             OPEN_DRAIN_SEL,
    output logic             IRQ
);
    asp_pkg::asp_state_type s, s_next;
    logic       op_tick;
    logic       freeze;
    logic       t_mid, t_end, r_mid, r_end, ir_win;
    logic       line;
    logic       apb_acc;
    logic [6:0] set_v;
    logic [6:0] clr_v;
    logic       tx_bit;
    logic       tx_par;
    logic [2:0] last_idx;

    // address decode behind the error answer, which also blocks writes
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= asp_pkg::OFS_INTE) && (a[1:0] == 2'h0);
    endfunction : mapped

    // operating clock: selected source divided, gated in debug
    always_comb
    begin
        freeze = s.dbg_s2 & ~s.clk_cfg[asp_pkg::C_DBR];
        op_tick = s.enable & ~freeze
            & CLK_SRC_TICK[s.clk_cfg[asp_pkg::C_SRC +: 2]]
            & (s.div_cnt == 3'((4'h1 << s.clk_cfg[asp_pkg::C_DIV +: 2])
                                - 4'h1));
    end

    asp_baud u_tx_baud (
        .clk     (MCLK),
        .rst_b   (RST_B),
        .tick    (op_tick),
        .run     (s.tx_st != asp_pkg::TX_IDLE),
        .baud_integer     (s.baud_integer),
        .frac    (s.frac),
        .div4    (s.mode[asp_pkg::M_DIV4]),
        .bit_mid (t_mid),
        .bit_end (t_end),
        .ir_win  (ir_win)
    );

    asp_baud u_rx_baud (
        .clk     (MCLK),
        .rst_b   (RST_B),
        .tick    (op_tick),
        .run     (s.rx_st != asp_pkg::RX_IDLE),
        .baud_integer     (s.baud_integer),
        .frac    (s.frac),
        .div4    (s.mode[asp_pkg::M_DIV4]),
        .bit_mid (r_mid),
        .bit_end (r_end),
        .ir_win  ()
    );

    // next-state logic of the whole channel
    always_comb
    begin
        s_next = s;
        set_v = 7'h0;
        clr_v = 7'h0;
        tx_bit = 1'b1;
        apb_acc = PSEL & PENABLE & s.pready;
        last_idx = s.mode[asp_pkg::M_DLEN] ? 3'h7 : 3'h6;
        tx_par = ^(s.tx_sh & {s.mode[asp_pkg::M_DLEN], 7'h7f})
                 ^ s.mode[asp_pkg::M_PODD];
        // pin synchronisers
        s_next.in_s1 = SERIAL_IN_PIN;
        s_next.in_s2 = s.in_s1;
        s_next.dbg_s1 = DEBUG_MODE;
        s_next.dbg_s2 = s.dbg_s1;
        // source divider and carrier wave
        if (s.enable & ~freeze & CLK_SRC_TICK[s.clk_cfg[asp_pkg::C_SRC +: 2]])
            s_next.div_cnt = op_tick ? 3'h0 : s.div_cnt + 3'h1;
        if (op_tick)
        begin
            s_next.car_cnt = (s.car_cnt == s.crper) ? 8'h0 : s.car_cnt + 8'h1;
            if (s.car_cnt == s.crper)
                s_next.car_wave = ~s.car_wave;
        end
        // input inversion and infrared demodulation
        line = s.in_s2 ^ s.mode[asp_pkg::M_RINV];
        if (s.mode[asp_pkg::M_IR])
        begin
            if (!line)
                s_next.ir_hold = 1'b1;
            else if (r_end)
                s_next.ir_hold = 1'b0;
            line = line & ~s.ir_hold;
        end
        else
            s_next.ir_hold = 1'b0;

        // APB: answer one cycle after setup
        s_next.pready = PSEL & ~PENABLE;
        if (PSEL & ~PENABLE)
        begin
            s_next.pslverr = ~mapped(PADDR);
            unique case (PADDR)
                asp_pkg::OFS_MODE: s_next.prdata = 32'(s.mode);
                asp_pkg::OFS_CTRL: s_next.prdata = 32'(s.enable);
                asp_pkg::OFS_CLK:  s_next.prdata = 32'(s.clk_cfg);
                asp_pkg::OFS_BAUD: s_next.prdata = 32'({s.frac, s.baud_integer});
                asp_pkg::OFS_CARR: s_next.prdata = 32'(s.crper);
                asp_pkg::OFS_TXD:  s_next.prdata = 32'(s.txbuf);
                asp_pkg::OFS_RXD:  s_next.prdata = 32'(s.fifo_d[0]);
                asp_pkg::OFS_INTF: s_next.prdata = 32'({
                                       s.rx_st != asp_pkg::RX_IDLE,
                                       s.tx_st != asp_pkg::TX_IDLE,
                                       1'b0, s.intf});
                asp_pkg::OFS_INTE: s_next.prdata = 32'(s.inte);
                default:           s_next.prdata = 32'h0;
            endcase
        end
        if (apb_acc & PWRITE & ~s.pslverr)
        begin
            unique case (PADDR)
                asp_pkg::OFS_MODE: s_next.mode = PWDATA[11:0];
                asp_pkg::OFS_CTRL: s_next.enable = PWDATA[0];
                asp_pkg::OFS_CLK:  s_next.clk_cfg = PWDATA[8:0];
                asp_pkg::OFS_BAUD:
                begin
                    s_next.baud_integer = PWDATA[7:0];
                    s_next.frac = PWDATA[11:8];
                end
                asp_pkg::OFS_CARR: s_next.crper = PWDATA[7:0];
                asp_pkg::OFS_TXD:
                begin
                    s_next.txbuf = PWDATA[7:0];
                    s_next.txbuf_full = 1'b1;
                    clr_v[asp_pkg::F_TBE] = 1'b1;
                end
                asp_pkg::OFS_INTF: clr_v = PWDATA[6:0];
                asp_pkg::OFS_INTE: s_next.inte = PWDATA[6:0];
                default:           s_next.inte = s.inte;
            endcase
        end
        // reading the receive data pops the head entry
        if (apb_acc & ~PWRITE & (PADDR == asp_pkg::OFS_RXD)
            & (s.fifo_cnt != 2'h0))
        begin
            s_next.fifo_d[0] = s.fifo_d[1];
            s_next.fifo_pe[0] = s.fifo_pe[1];
            s_next.fifo_fe[0] = s.fifo_fe[1];
            s_next.fifo_cnt = s.fifo_cnt - 2'h1;
            if (s.fifo_cnt == 2'h2)
            begin
                set_v[asp_pkg::F_PE] = s.fifo_pe[1];
                set_v[asp_pkg::F_FE] = s.fifo_fe[1];
            end
        end

        // transmitter
        unique case (s.tx_st)
            asp_pkg::TX_IDLE:
                if (s.txbuf_full & s.enable & ~freeze)
                begin
                    s_next.tx_sh = s.txbuf;
                    s_next.txbuf_full = 1'b0;
                    set_v[asp_pkg::F_TBE] = 1'b1;
                    s_next.tx_st = asp_pkg::TX_START;
                end
            asp_pkg::TX_START:
            begin
                tx_bit = 1'b0;
                if (t_end)
                begin
                    s_next.tx_idx = 3'h0;
                    s_next.tx_st = asp_pkg::TX_DATA;
                end
            end
            asp_pkg::TX_DATA:
            begin
                tx_bit = s.tx_sh[s.tx_idx];
                if (t_end)
                begin
                    s_next.tx_idx = s.tx_idx + 3'h1;
                    s_next.tx_stop2 = 1'b0;
                    if (s.tx_idx == last_idx)
                        s_next.tx_st = s.mode[asp_pkg::M_PEN]
                            ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
                end
            end
            asp_pkg::TX_PAR:
            begin
                tx_bit = tx_par;
                if (t_end)
                    s_next.tx_st = asp_pkg::TX_STOP;
            end
            asp_pkg::TX_STOP:
                if (t_end)
                begin
                    if (s.mode[asp_pkg::M_STOP] & ~s.tx_stop2)
                        s_next.tx_stop2 = 1'b1;
                    else if (s.txbuf_full)
                    begin
                        s_next.tx_sh = s.txbuf;
                        s_next.txbuf_full = 1'b0;
                        set_v[asp_pkg::F_TBE] = 1'b1;
                        s_next.tx_st = asp_pkg::TX_START;
                    end
                    else
                    begin
                        set_v[asp_pkg::F_TEND] = 1'b1;
                        s_next.tx_st = asp_pkg::TX_IDLE;
                    end
                end
        endcase

        // receiver
        unique case (s.rx_st)
            asp_pkg::RX_IDLE:
                if (~line & s.enable & ~freeze)
                begin
                    s_next.rx_st = asp_pkg::RX_START;
                    s_next.rx_sh = 8'h0;
                    s_next.rx_perr = 1'b0;
                    s_next.rx_ferr = 1'b0;
                    s_next.rx_stop2 = 1'b0;
                end
            asp_pkg::RX_START:
                if (r_mid & line)
                begin
                    s_next.rx_st = asp_pkg::RX_IDLE;
                    s_next.ir_hold = 1'b0;
                end
                else if (r_end)
                begin
                    s_next.rx_idx = 3'h0;
                    s_next.rx_st = asp_pkg::RX_DATA;
                end
            asp_pkg::RX_DATA:
            begin
                if (r_mid)
                    s_next.rx_sh[s.rx_idx] = line;
                if (r_end)
                begin
                    s_next.rx_idx = s.rx_idx + 3'h1;
                    if (s.rx_idx == last_idx)
                        s_next.rx_st = s.mode[asp_pkg::M_PEN]
                            ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
                end
            end
            asp_pkg::RX_PAR:
            begin
                if (r_mid)
                    s_next.rx_perr = (^s.rx_sh ^ line)
                        != s.mode[asp_pkg::M_PODD];
                if (r_end)
                    s_next.rx_st = asp_pkg::RX_STOP;
            end
            asp_pkg::RX_STOP:
            begin
                if (r_mid & ~line)
                    s_next.rx_ferr = 1'b1;
                if (r_end)
                    s_next.rx_stop2 = 1'b1;
                if (r_mid & ~(s.mode[asp_pkg::M_STOP] & ~s.rx_stop2))
                begin
                    s_next.rx_st = asp_pkg::RX_IDLE;
                    if (s_next.fifo_cnt == 2'h2)
                        set_v[asp_pkg::F_OE] = 1'b1;
                    else
                    begin
                        s_next.fifo_d[s_next.fifo_cnt[0]] = s.rx_sh;
                        s_next.fifo_pe[s_next.fifo_cnt[0]] = s.rx_perr;
                        s_next.fifo_fe[s_next.fifo_cnt[0]] = s.rx_ferr | ~line;
                        if (s_next.fifo_cnt == 2'h0)
                        begin
                            set_v[asp_pkg::F_RX1] = 1'b1;
                            set_v[asp_pkg::F_PE] = s.rx_perr;
                            set_v[asp_pkg::F_FE] = s.rx_ferr | ~line;
                        end
                        else
                            set_v[asp_pkg::F_RX2] = 1'b1;
                        s_next.fifo_cnt = s_next.fifo_cnt + 2'h1;
                    end
                end
            end
        endcase

        // sticky cause flags: set wins over clear
        s_next.intf = (s.intf & ~clr_v) | set_v;
        s_next.irq = |(s_next.intf & s.inte);

        // output path: infrared, carrier, inversion, pad mode
        if (s.mode[asp_pkg::M_IR])
            tx_bit = ~(~tx_bit & ir_win);
        if (s.mode[asp_pkg::M_CEN] & (tx_bit == s.mode[asp_pkg::M_CSEL]))
            tx_bit = s.car_wave;
        if (!s.enable)
            tx_bit = 1'b1;
        s_next.serial_out = tx_bit ^ s.mode[asp_pkg::M_TINV];
        s_next.out_oe = ~s.mode[asp_pkg::M_OD] | ~s_next.serial_out;
    end

    // state register
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s <= '0;
            s.tx_st <= asp_pkg::TX_IDLE;
            s.rx_st <= asp_pkg::RX_IDLE;
            s.mode <= asp_pkg::MODE_RST;
            s.baud_integer <= asp_pkg::BRT_RST;
            s.frac <= asp_pkg::FMD_RST;
            s.crper <= asp_pkg::CRP_RST;
            s.intf <= asp_pkg::INTF_RST;
            s.in_s1 <= 1'b1;
            s.in_s2 <= 1'b1;
            s.serial_out <= 1'b1;
            s.out_oe <= 1'b1;
        end
        else
            s <= s_next;
    end

    // outputs straight from the state register
    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign SERIAL_OUT_PIN = s.serial_out;
    assign SERIAL_OUT_OE = s.out_oe;
    assign INPUT_PULLUP_EN = s.mode[asp_pkg::M_PUP];
    assign OPEN_DRAIN_SEL = s.mode[asp_pkg::M_OD];
    assign IRQ = s.irq;
endmodule : asp_channel
`default_nettype wire

// *** test/asp_properties.sv ***
// Purpose: port properties of the serial channel
// Assumes: one MCLK domain, RST_B async low
// Notes:   bound to asp_channel below
`timescale 1ns/1ps
`default_nettype none
module asp_checker (
    input wire logic        MCLK,
    input wire logic        RST_B,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SERIAL_OUT_OE,
    input wire logic        INPUT_PULLUP_EN,
    input wire logic        OPEN_DRAIN_SEL,
    input wire logic        IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // completed write to one register
    sequence s_wr(logic [7:0] a);
        PSEL && PENABLE && PREADY && PWRITE && PADDR == a;
    endsequence
    // setup cycle then first access cycle
    sequence s_acc;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    chk_ready_first: assert property (s_acc |-> PREADY)
        else $error("no ready in first access");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    chk_ready_qual: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    chk_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("refused read not zero");
    chk_pullup_pad: assert property (
        s_wr(asp_pkg::OFS_MODE) ##2 1 |-> INPUT_PULLUP_EN == $past(PWDATA[7], 2))
        else $error("pullup pad wrong");
    chk_drain_pad: assert property (
        s_wr(asp_pkg::OFS_MODE) ##2 1 |-> OPEN_DRAIN_SEL == $past(PWDATA[8], 2))
        else $error("open drain pad wrong");
    chk_pushpull_oe: assert property (
        !OPEN_DRAIN_SEL [*3] |-> $past(SERIAL_OUT_OE))
        else $error("push-pull output not driven");
    chk_irq_masked: assert property (
        s_wr(asp_pkg::OFS_INTE) ##0 PWDATA[6:0] == 7'h0 |-> ##2 !IRQ)
        else $error("irq with all causes masked");
endmodule : asp_checker
bind asp_channel asp_checker asp_checker_i (.MCLK(MCLK), .RST_B(RST_B),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SERIAL_OUT_OE(SERIAL_OUT_OE), .INPUT_PULLUP_EN(INPUT_PULLUP_EN),
    .OPEN_DRAIN_SEL(OPEN_DRAIN_SEL), .IRQ(IRQ));
`default_nettype wire

// *** test/asp_partner.sv ***
// Purpose: far-end serial device model
// Assumes: 16 MCLK per bit
// Notes:   line idles high as if pulled up
`timescale 1ns/1ps
`default_nettype none
module asp_partner (
    input wire logic clk,
    input wire logic line_in,
    output logic     line_out
);
    logic [11:0] cap;
    initial line_out = 1'b1;
    // one frame lsb first, then an idle bit
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++)
        begin
            line_out <= f[i];
            repeat (16) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (16) @(posedge clk);
    endtask : send
    // mid-bit samples of each incoming frame
    always
    begin
        @(negedge line_in);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 12; i++)
        begin
            cap[i] = line_in;
            repeat (16) @(posedge clk);
        end
    end
endmodule : asp_partner
`default_nettype wire

// *** test/asp_channel_tb.sv ***
// Purpose: self-checking bench of the serial channel
// Assumes: source ticks every MCLK, 16 MCLK per bit
// Notes:   APB master tasks, partner drives the input line
`timescale 1ns/1ps
`default_nettype none
module asp_channel_tb;
    logic        mclk, rst_b, psel, penable, pwrite, slv, sin, dbg;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, sout, soe, pup, od, irq;
    int          n_errors, checked;
    asp_channel asp_channel_i (.MCLK(mclk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CLK_SRC_TICK(4'hf), .DEBUG_MODE(dbg), .SERIAL_IN_PIN(sin),
        .SERIAL_OUT_PIN(sout), .SERIAL_OUT_OE(soe), .INPUT_PULLUP_EN(pup),
        .OPEN_DRAIN_SEL(od), .IRQ(irq));
    asp_partner asp_partner_i (.clk(mclk), .line_in(sout), .line_out(sin));
    // clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, waits for ready
    task automatic xfer(input logic w, input logic [7:0] a, input int d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // clock, rate and format before enable
    task automatic cfg(input int m);
        xfer(1, asp_pkg::OFS_CTRL, 0);
        xfer(1, asp_pkg::OFS_CLK, 0);
        xfer(1, asp_pkg::OFS_BAUD, 0);
        xfer(1, asp_pkg::OFS_MODE, m);
        xfer(1, asp_pkg::OFS_CTRL, 1);
        xfer(1, asp_pkg::OFS_INTF, 32'h7f);
    endtask : cfg
    // reset values, refusal, pads
    task automatic t_regs;
        xfer(0, asp_pkg::OFS_INTF, 0);
        chk(q, 32'h4);
        xfer(0, 8'h24, 0);
        chk({slv, q[30:0]}, 32'h80000000);
        xfer(1, asp_pkg::OFS_MODE, 32'h180);
        repeat (2) @(posedge mclk);
        chk({pup, od, soe, sout}, 4'hd);
        xfer(1, asp_pkg::OFS_MODE, 0);
        repeat (2) @(posedge mclk);
        chk({pup, od, soe, sout}, 4'h3);
    endtask : t_regs
    // 8 bits, even parity, two stops
    task automatic t_tx;
        cfg(32'h7);
        dbg <= 1'b1;
        xfer(1, asp_pkg::OFS_TXD, 32'ha5);
        xfer(0, asp_pkg::OFS_INTF, 0);
        chk({q[8], q[2]}, 2'h0);
        dbg <= 1'b0;
        repeat (4) @(posedge mclk);
        xfer(0, asp_pkg::OFS_INTF, 0);
        chk({q[8], q[2]}, 2'h3);
        for (int n = 0; n < 100 && q[3] !== 1'b1; n++)
            xfer(0, asp_pkg::OFS_INTF, 0);
        chk({q[8], q[3]}, 2'h1);
        chk(asp_partner_i.cap, 12'hd4a);
    endtask : t_tx
    // 7 bits odd parity: good, bad stop, overrun
    task automatic t_rx;
        cfg(32'hc);
        asp_partner_i.send({2'h3, 7'h35, 1'b0}, 10);
        asp_partner_i.send({2'h1, 7'h12, 1'b0}, 10);
        asp_partner_i.send({2'h2, 7'h7f, 1'b0}, 10);
        xfer(0, asp_pkg::OFS_INTF, 0);
        chk(q[6:0] & 7'h73, 7'h43);
        xfer(1, asp_pkg::OFS_INTE, 1);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        xfer(1, asp_pkg::OFS_INTE, 0);
        xfer(0, asp_pkg::OFS_RXD, 0);
        chk(q, 32'h35);
        xfer(0, asp_pkg::OFS_INTF, 0);
        chk(q[5], 1'b1);
        xfer(0, asp_pkg::OFS_RXD, 0);
        chk(q, 32'h12);
        xfer(0, asp_pkg::OFS_RXD, 0);
        chk(q, 32'h12);
        xfer(1, asp_pkg::OFS_INTF, 32'h7f);
        xfer(0, asp_pkg::OFS_INTF, 0);
        chk({irq, q[6:0]}, 8'h0);
        xfer(1, asp_pkg::OFS_CTRL, 0);
        xfer(1, asp_pkg::OFS_MODE, 32'h40);
        repeat (2) @(posedge mclk);
        chk(sout, 1'b0);
        xfer(1, asp_pkg::OFS_MODE, 32'hc00);
        xfer(1, asp_pkg::OFS_CTRL, 1);
        repeat (2) @(posedge mclk);
        slv = sout;
        @(posedge mclk);
        chk(sout, {31'h0, ~slv});
    endtask : t_rx
    // verdict and end of run
    task automatic close_out;
        if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // main sequence
    initial
    begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, dbg} = '0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs;
        t_tx;
        t_rx;
        close_out;
    end
    // watchdog
    initial
    begin
        #1ms;
        n_errors++;
        close_out;
    end
endmodule : asp_channel_tb
`default_nettype wire
